// ### src/clk_ratio_div.sv
// Card clock divider: divides the oscillator by 1, 2, 4 or 6.
// Assumes osc_in is asynchronous; it passes two flip-flops here, and
// divide by one follows the synchronised oscillator directly.
`timescale 1ns/1ps
module clk_ratio_div (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic osc_in,
    input wire logic [1:0] ratio_in,
    input wire logic run_in,
    output logic card_clk_out
);
    typedef struct packed {
        logic [1:0] osc_s;
        logic osc_d;
        logic [2:0] cnt;
        logic clk;
    } div_st_t;

    div_st_t st_ff, nxt_st;
    logic [2:0] half;
    logic osc;

    assign osc = st_ff.osc_s[1];

    // ------------------------------------------------------------
    // Divider
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        half = sc_seq_pkg::HALF_DIV2;
        unique case (ratio_in)
            sc_seq_pkg::RATIO_DIV6: half = sc_seq_pkg::HALF_DIV6;
            sc_seq_pkg::RATIO_DIV4: half = sc_seq_pkg::HALF_DIV4;
            sc_seq_pkg::RATIO_DIV2: half = sc_seq_pkg::HALF_DIV2;
            sc_seq_pkg::RATIO_DIV1: half = sc_seq_pkg::HALF_DIV2;
        endcase
        nxt_st.osc_s = {st_ff.osc_s[0], osc_in};
        nxt_st.osc_d = osc;
        if (!run_in) begin
            nxt_st.cnt = 3'h0;
            nxt_st.clk = 1'b0;
        end else if (ratio_in == sc_seq_pkg::RATIO_DIV1) begin
            nxt_st.clk = osc;
        end else if (osc && !st_ff.osc_d) begin
            // Count oscillator rising edges; toggle every half period
            if (st_ff.cnt + 3'h1 >= half) begin
                nxt_st.cnt = 3'h0;
                nxt_st.clk = ~st_ff.clk;
            end else begin
                nxt_st.cnt = st_ff.cnt + 3'h1;
            end
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign card_clk_out = st_ff.clk;

    clk_stops_a: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !run_in |=> !card_clk_out)
        else $error("card clock runs while stopped");
endmodule

// ### src/sc_seq_pkg.sv
// Constants and carrier types for the smart card interface sequencer.
// Assumes a 100 MHz reference clock; all other inputs arrive asynchronously.
package sc_seq_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int LOCKOUT_MS = 10;
    localparam int LOCKOUT_CYC = LOCKOUT_MS * 1000000 / CLK_PERIOD_NS;
    localparam int T_STEP_DEF = 16;
    localparam int TW = 24;

    // ------------------------------------------------------------
    // Clock ratio select codes {sel_a, sel_b}
    // ------------------------------------------------------------
    localparam logic [1:0] RATIO_DIV6 = 2'h0;
    localparam logic [1:0] RATIO_DIV4 = 2'h1;
    localparam logic [1:0] RATIO_DIV1 = 2'h2;
    localparam logic [1:0] RATIO_DIV2 = 2'h3;
    localparam logic [2:0] HALF_DIV6 = 3'h3;
    localparam logic [2:0] HALF_DIV4 = 3'h2;
    localparam logic [2:0] HALF_DIV2 = 3'h1;

    typedef enum logic [3:0] {
        SEQ_IDLE, SEQ_RAMP, SEQ_T2, SEQ_T3, SEQ_WAIT_RST, SEQ_ACTIVE,
        SEQ_D1, SEQ_D2, SEQ_D3, SEQ_D4, SEQ_D5
    } seq_state_t;

    typedef enum logic [1:0] {
        IO_NEUTRAL, IO_CARD_IN, IO_HOST_IN
    } io_dir_t;

    // Card-side outputs carried together
    typedef struct packed {
        logic vcc_on;
        logic vcc_5v;
        logic rst;
        logic clk_en;
        logic io_rx;
    } card_ctl_t;

endpackage

// ### src/sc_sequencer.sv
// Smart card activation/deactivation sequencer with I/O direction relay.
// Assumes all pins are asynchronous to ref_clk_in; analog supervisors
// deliver fault levels; the oscillator is well below the reference rate.
//
// What this block does
// - Card clock divides oscillator by select inputs
// - Ignore activation for 10ms after supply good
// - Activation starts on command falling edge
// - Activate only with card present, no logic supply fault
// - Card supply invalid at t1: flag, power off
// - Reset low: receive at t2, clock t3
// - Reset high: clock on reset falling edge
// - Deactivate on command release or faults
// - Deactivate: RST, clock, data, supply, discharge
// - In idle interrupt shows presence only
// - In session faults drop interrupt, deactivate
// - Reset: card data low, host data high
// - First falling edge line becomes input
// - Input rising edge returns lines to neutral
// - Supply level 5V high, 3V low select
// - Supply fault holds sequencer, forces deactivation
`timescale 1ns/1ps
module sc_sequencer #(
    parameter int LOCKOUT_CYC = sc_seq_pkg::LOCKOUT_CYC,
    parameter int T1_CYC = sc_seq_pkg::T_STEP_DEF,
    parameter int T2_CYC = sc_seq_pkg::T_STEP_DEF,
    parameter int T3_CYC = sc_seq_pkg::T_STEP_DEF,
    parameter int T4_CYC = sc_seq_pkg::T_STEP_DEF,
    parameter int T5_CYC = sc_seq_pkg::T_STEP_DEF
) (
    input wire logic ref_clk_in,
    input wire logic rst_b_in,
    input wire logic osc_input_in,
    input wire logic activation_command_n_in,
    input wire logic host_reset_request_in,
    input wire logic card_voltage_select_in,
    input wire logic clock_ratio_sel_a_in,
    input wire logic clock_ratio_sel_b_in,
    input wire logic card_detect_in,
    input wire logic logic_supply_fault_in,
    input wire logic card_overcurrent_in,
    input wire logic card_supply_valid_in,
    input wire logic card_io_in,
    input wire logic host_side_io_in,
    output logic osc_output_out,
    output logic card_clk_out,
    output logic card_rst_out,
    output logic card_vcc_on_out,
    output logic card_vcc_5v_out,
    output logic card_vcc_discharge_out,
    output logic card_io_out,
    output logic card_io_oe_out,
    output logic host_side_io_out,
    output logic host_side_io_oe_out,
    output logic fault_irq_n_out,
    output logic fault_irq_n_oe_out
);
    localparam int SYNC_N = 9;

    typedef struct packed {
        logic [SYNC_N-1:0] s1;
        logic [SYNC_N-1:0] s2;
        logic cmd_d;
        logic hrst_d;
        logic cio_d;
        logic hio_d;
        sc_seq_pkg::seq_state_t state;
        sc_seq_pkg::io_dir_t dir;
        logic [sc_seq_pkg::TW-1:0] cnt;
        logic [sc_seq_pkg::TW-1:0] lock;
        logic locked;
        sc_seq_pkg::card_ctl_t ctl;
        logic discharge;
        logic irq_n;
        logic cio_o;
        logic cio_oe;
        logic hio_o;
        logic hio_oe;
    } seq_st_t;

    seq_st_t st_ff, nxt_st;
    logic cmd, hrst, vsel, card_detect, logic_supply_fault, ocur, vccok, cio, hio;
    logic session, fault, cmd_fall, hrst_fall, cio_fall, hio_fall;
    logic cio_rise, hio_rise, card_clk;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    assign {cmd, hrst, vsel, card_detect, logic_supply_fault, ocur, vccok, cio, hio} = st_ff.s2;
    assign cmd_fall = st_ff.cmd_d && !cmd;
    assign hrst_fall = st_ff.hrst_d && !hrst;
    assign cio_fall = st_ff.cio_d && !cio;
    assign hio_fall = st_ff.hio_d && !hio;
    assign cio_rise = !st_ff.cio_d && cio;
    assign hio_rise = !st_ff.hio_d && hio;
    assign session = st_ff.state inside {sc_seq_pkg::SEQ_RAMP,
        sc_seq_pkg::SEQ_T2, sc_seq_pkg::SEQ_T3, sc_seq_pkg::SEQ_WAIT_RST,
        sc_seq_pkg::SEQ_ACTIVE};
    // Supply still ramps in RAMP; its check there is the t1 test
    assign fault = logic_supply_fault || ocur || !card_detect
        || (!vccok && st_ff.state != sc_seq_pkg::SEQ_RAMP);

    // ------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = {activation_command_n_in, host_reset_request_in,
            card_voltage_select_in, card_detect_in, logic_supply_fault_in,
            card_overcurrent_in, card_supply_valid_in, card_io_in,
            host_side_io_in};
        nxt_st.s2 = st_ff.s1;
        nxt_st.cmd_d = cmd;
        nxt_st.hrst_d = hrst;
        nxt_st.cio_d = cio;
        nxt_st.hio_d = hio;
        nxt_st.cnt = st_ff.cnt + 24'h1;
        // Lockout restarts whenever the logic supply faults
        if (logic_supply_fault) begin
            nxt_st.lock = 24'h0;
            nxt_st.locked = 1'b1;
        end else if (st_ff.lock >= sc_seq_pkg::TW'(LOCKOUT_CYC - 1)) begin
            nxt_st.locked = 1'b0;
        end else begin
            nxt_st.lock = st_ff.lock + 24'h1;
        end
        // A fault report stands through deactivation
        if (st_ff.state == sc_seq_pkg::SEQ_IDLE) begin
            nxt_st.irq_n = card_detect;
        end
        unique case (st_ff.state)
            sc_seq_pkg::SEQ_IDLE: begin
                nxt_st.discharge = 1'b0;
                // Faults here cause no deactivation
                if (cmd_fall && card_detect && !logic_supply_fault && !st_ff.locked) begin
                    nxt_st.state = sc_seq_pkg::SEQ_RAMP;
                    nxt_st.cnt = '0;
                    nxt_st.ctl.vcc_on = 1'b1;
                    nxt_st.ctl.vcc_5v = vsel;
                end
            end
            sc_seq_pkg::SEQ_RAMP: begin
                if (st_ff.cnt >= sc_seq_pkg::TW'(T1_CYC - 1)) begin
                    nxt_st.cnt = '0;
                    if (!vccok) begin
                        nxt_st.irq_n = 1'b0;
                        nxt_st.ctl.vcc_on = 1'b0;
                        nxt_st.state = sc_seq_pkg::SEQ_D1;
                    end else if (hrst) begin
                        nxt_st.state = sc_seq_pkg::SEQ_WAIT_RST;
                    end else begin
                        nxt_st.state = sc_seq_pkg::SEQ_T2;
                    end
                end
            end
            sc_seq_pkg::SEQ_T2: begin
                if (st_ff.cnt >= sc_seq_pkg::TW'(T2_CYC - 1)) begin
                    nxt_st.ctl.io_rx = 1'b1;
                    nxt_st.cnt = '0;
                    nxt_st.state = sc_seq_pkg::SEQ_T3;
                end
            end
            sc_seq_pkg::SEQ_T3: begin
                if (st_ff.cnt >= sc_seq_pkg::TW'(T3_CYC - 1)) begin
                    nxt_st.ctl.clk_en = 1'b1;
                    nxt_st.state = sc_seq_pkg::SEQ_ACTIVE;
                end
            end
            sc_seq_pkg::SEQ_WAIT_RST: begin
                nxt_st.ctl.io_rx = 1'b1;
                if (hrst_fall) begin
                    nxt_st.ctl.clk_en = 1'b1;
                    nxt_st.state = sc_seq_pkg::SEQ_ACTIVE;
                end
            end
            sc_seq_pkg::SEQ_ACTIVE: begin
                nxt_st.ctl.rst = hrst;
            end
            sc_seq_pkg::SEQ_D1: begin
                if (st_ff.cnt >= sc_seq_pkg::TW'(T1_CYC - 1)) begin
                    nxt_st.ctl.rst = 1'b0;
                    nxt_st.cnt = '0;
                    nxt_st.state = sc_seq_pkg::SEQ_D2;
                end
            end
            sc_seq_pkg::SEQ_D2: begin
                if (st_ff.cnt >= sc_seq_pkg::TW'(T2_CYC - 1)) begin
                    nxt_st.ctl.clk_en = 1'b0;
                    nxt_st.cnt = '0;
                    nxt_st.state = sc_seq_pkg::SEQ_D3;
                end
            end
            sc_seq_pkg::SEQ_D3: begin
                if (st_ff.cnt >= sc_seq_pkg::TW'(T3_CYC - 1)) begin
                    nxt_st.ctl.io_rx = 1'b0;
                    nxt_st.cnt = '0;
                    nxt_st.state = sc_seq_pkg::SEQ_D4;
                end
            end
            sc_seq_pkg::SEQ_D4: begin
                if (st_ff.cnt >= sc_seq_pkg::TW'(T4_CYC - 1)) begin
                    nxt_st.ctl.vcc_on = 1'b0;
                    nxt_st.discharge = 1'b1;
                    nxt_st.cnt = '0;
                    nxt_st.state = sc_seq_pkg::SEQ_D5;
                end
            end
            sc_seq_pkg::SEQ_D5: begin
                if (st_ff.cnt >= sc_seq_pkg::TW'(T5_CYC - 1)) begin
                    nxt_st.discharge = 1'b0;
                    nxt_st.state = sc_seq_pkg::SEQ_IDLE;
                end
            end
            default: nxt_st.state = sc_seq_pkg::SEQ_IDLE;
        endcase
        // Deactivation overrides any activation step in progress
        if (session && (cmd || fault)) begin
            nxt_st.state = sc_seq_pkg::SEQ_D1;
            nxt_st.cnt = '0;
            if (fault) begin
                nxt_st.irq_n = 1'b0;
            end
        end
        // Data line relay, only while reception is enabled
        if (!st_ff.ctl.io_rx || !session) begin
            nxt_st.dir = sc_seq_pkg::IO_NEUTRAL;
        end else begin
            unique case (st_ff.dir)
                sc_seq_pkg::IO_NEUTRAL: begin
                    // Card wins a tie; simultaneous starts are illegal
                    if (cio_fall) begin
                        nxt_st.dir = sc_seq_pkg::IO_CARD_IN;
                    end else if (hio_fall) begin
                        nxt_st.dir = sc_seq_pkg::IO_HOST_IN;
                    end
                end
                sc_seq_pkg::IO_CARD_IN: begin
                    if (cio_rise) begin
                        nxt_st.dir = sc_seq_pkg::IO_NEUTRAL;
                    end
                end
                sc_seq_pkg::IO_HOST_IN: begin
                    if (hio_rise) begin
                        nxt_st.dir = sc_seq_pkg::IO_NEUTRAL;
                    end
                end
                default: nxt_st.dir = sc_seq_pkg::IO_NEUTRAL;
            endcase
        end
        // Open-drain style: drive low only, release for high
        nxt_st.cio_o = 1'b0;
        nxt_st.hio_o = 1'b0;
        nxt_st.cio_oe = !nxt_st.ctl.io_rx;
        nxt_st.hio_oe = 1'b0;
        if (nxt_st.dir == sc_seq_pkg::IO_CARD_IN) begin
            nxt_st.hio_oe = !cio;
        end else if (nxt_st.dir == sc_seq_pkg::IO_HOST_IN) begin
            nxt_st.cio_oe = !hio;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            st_ff <= '0;
            st_ff.s1 <= '1;
            st_ff.s2 <= '1;
            st_ff.cmd_d <= 1'b1;
            st_ff.hrst_d <= 1'b1;
            st_ff.cio_d <= 1'b1;
            st_ff.hio_d <= 1'b1;
            st_ff.state <= sc_seq_pkg::SEQ_IDLE;
            st_ff.dir <= sc_seq_pkg::IO_NEUTRAL;
            st_ff.locked <= 1'b1;
            st_ff.irq_n <= 1'b1;
            st_ff.cio_oe <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // ------------------------------------------------------------
    // Card clock divider and outputs
    // ------------------------------------------------------------
    clk_ratio_div u_div (
        .ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in),
        .osc_in(osc_input_in),
        .ratio_in({clock_ratio_sel_a_in, clock_ratio_sel_b_in}),
        .run_in(st_ff.ctl.clk_en),
        .card_clk_out(card_clk)
    );

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            card_clk_out <= 1'b0;
            osc_output_out <= 1'b1;
        end else begin
            card_clk_out <= card_clk;
            osc_output_out <= ~osc_input_in;
        end
    end

    assign card_rst_out = st_ff.ctl.rst;
    assign card_vcc_on_out = st_ff.ctl.vcc_on;
    assign card_vcc_5v_out = st_ff.ctl.vcc_5v;
    assign card_vcc_discharge_out = st_ff.discharge;
    assign card_io_out = st_ff.cio_o;
    assign card_io_oe_out = st_ff.cio_oe;
    assign host_side_io_out = st_ff.hio_o;
    assign host_side_io_oe_out = st_ff.hio_oe;
    assign fault_irq_n_out = 1'b0;
    assign fault_irq_n_oe_out = !st_ff.irq_n;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    lockout_blocks_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        st_ff.locked |=> !$rose(card_vcc_on_out))
        else $error("activation during lockout");
    no_fault_start_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        $rose(card_vcc_on_out) |-> $past(card_detect) && !$past(logic_supply_fault))
        else $error("activation without card or with fault");
    vcc_check_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        st_ff.state == sc_seq_pkg::SEQ_RAMP && !nxt_st.ctl.vcc_on
        |=> !fault_irq_n_oe_out == 1'b0 && !card_vcc_on_out)
        else $error("bad supply not reported");
    fault_deact_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        session && fault |=> st_ff.state == sc_seq_pkg::SEQ_D1
        && fault_irq_n_oe_out)
        else $error("fault did not start deactivation");
    cmd_deact_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        session && cmd |=> st_ff.state == sc_seq_pkg::SEQ_D1)
        else $error("command release ignored");
    idle_irq_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        st_ff.state == sc_seq_pkg::SEQ_IDLE && $past(!session)
        |=> fault_irq_n_oe_out == !$past(card_detect))
        else $error("idle interrupt not presence");
    rst_order_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        $fell(card_vcc_on_out) && st_ff.state == sc_seq_pkg::SEQ_D5
        |-> !card_rst_out && !st_ff.ctl.clk_en && !st_ff.ctl.io_rx)
        else $error("deactivation order broken");
    io_idle_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        !st_ff.ctl.io_rx |-> card_io_oe_out && !host_side_io_oe_out)
        else $error("data lines not idle");
    io_neutral_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        st_ff.dir == sc_seq_pkg::IO_CARD_IN && cio_rise && session
        && st_ff.ctl.io_rx |=> st_ff.dir == sc_seq_pkg::IO_NEUTRAL)
        else $error("direction not released");
    rst_follow_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_b_in)
        st_ff.state == sc_seq_pkg::SEQ_ACTIVE ##1
        st_ff.state == sc_seq_pkg::SEQ_ACTIVE |-> card_rst_out == $past(hrst))
        else $error("card reset not following host");

    act_c: cover property (@(posedge ref_clk_in)
        st_ff.state == sc_seq_pkg::SEQ_ACTIVE);
    wait_c: cover property (@(posedge ref_clk_in)
        st_ff.state == sc_seq_pkg::SEQ_WAIT_RST ##1
        st_ff.state == sc_seq_pkg::SEQ_ACTIVE);
    host_in_c: cover property (@(posedge ref_clk_in)
        st_ff.dir == sc_seq_pkg::IO_HOST_IN);
    deact_c: cover property (@(posedge ref_clk_in)
        st_ff.state == sc_seq_pkg::SEQ_D5 ##1
        st_ff.state == sc_seq_pkg::SEQ_IDLE);
endmodule

// ### testbench/sc_card_model.sv
// Card stand-in: answers each rise of its reset with one low data pulse.
// Assumes the bench resolves the open-drain data wire with a pull-up.
`timescale 1ns/1ps
module sc_card_model (
    input wire logic ref_clk_in,
    input wire logic card_rst_in,
    input wire logic card_vcc_on_in,
    output logic io_pull_out
);
    logic rst_q = 1'b0;
    int cnt = 0;
    always @(posedge ref_clk_in) begin
        rst_q <= card_rst_in;
        if (card_rst_in && !rst_q && card_vcc_on_in) begin
            cnt <= 1;
        end else if (cnt != 0) begin
            cnt <= (cnt == 50) ? 0 : cnt + 1;
        end
    end
    // Unpowered card never pulls, so a dead card leaves the line high
    assign io_pull_out = card_vcc_on_in && cnt > 30;
endmodule

// ### testbench/tb_smart_card_interface_sequencer.sv
// Self-checking bench for the sequencer, with a card model on the far side.
// Assumes short lockout and step counts; open-drain wires resolved here.
`timescale 1ns/1ps
module tb_smart_card_interface_sequencer;
    // ------------------------------------------------------------
    // Model figures
    // ------------------------------------------------------------
    localparam int LOCK = 50;
    localparam int T1 = 6;
    localparam int T2 = 8;
    localparam int T3 = 10;
    localparam int T4 = 12;
    localparam int T5 = 14;
    int divs[4] = '{6, 4, 1, 2};
    int gaps[$] = '{T2 + T3, T4, T5};
    logic ref_clk_in = 1'b0;
    logic rst_b_in = 1'b0;
    logic osc = 1'b0;
    logic cmd_n = 1'b1;
    logic host_rst = 1'b0;
    logic vsel = 1'b1;
    logic [1:0] ratio = 2'h0;
    logic detect = 1'b1;
    logic lfault = 1'b0;
    logic ocur = 1'b0;
    logic vvalid = 1'b1;
    logic host_pull = 1'b0;
    logic card_pull, card_io, host_io, card_clk, card_rst, vcc_on, vcc_5v;
    logic vcc_dis, cio_oe, hio_oe, irq_oe;
    int err_total = 0;
    int tests_run = 0;
    integer seed = 50;
    int n;
    always #5 ref_clk_in = ~ref_clk_in;
    always #60 osc = ~osc;
    assign card_io = ~(cio_oe | card_pull);
    assign host_io = ~(hio_oe | host_pull);
    sc_sequencer #(.LOCKOUT_CYC(LOCK), .T1_CYC(T1), .T2_CYC(T2),
        .T3_CYC(T3), .T4_CYC(T4), .T5_CYC(T5)) sc_sequencer_inst (
        .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in), .osc_input_in(osc),
        .activation_command_n_in(cmd_n), .host_reset_request_in(host_rst),
        .card_voltage_select_in(vsel), .clock_ratio_sel_a_in(ratio[1]),
        .clock_ratio_sel_b_in(ratio[0]), .card_detect_in(detect),
        .logic_supply_fault_in(lfault), .card_overcurrent_in(ocur),
        .card_supply_valid_in(vvalid), .card_io_in(card_io),
        .host_side_io_in(host_io), .osc_output_out(),
        .card_clk_out(card_clk), .card_rst_out(card_rst),
        .card_vcc_on_out(vcc_on), .card_vcc_5v_out(vcc_5v),
        .card_vcc_discharge_out(vcc_dis), .card_io_out(),
        .card_io_oe_out(cio_oe), .host_side_io_out(),
        .host_side_io_oe_out(hio_oe), .fault_irq_n_out(),
        .fault_irq_n_oe_out(irq_oe));
    sc_card_model sc_card_model_inst (.ref_clk_in(ref_clk_in),
        .card_rst_in(card_rst), .card_vcc_on_in(vcc_on),
        .io_pull_out(card_pull));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic complete_run();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen,
                         input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // Sync latency shifts counts a little, so allow a small window
    task automatic near(input string nm, input int seen, input int exp);
        check(nm, (seen >= exp - 1 && seen <= exp + 2) ? exp : seen, exp);
    endtask
    function automatic logic sig(input int k);
        case (k)
            0: sig = vcc_on;
            1: sig = cio_oe;
            2: sig = card_rst;
            3: sig = irq_oe;
            4: sig = hio_oe;
            5: sig = vcc_dis;
            default: sig = card_clk;
        endcase
    endfunction
    task automatic wait_for(input int k, input logic v, input int lim,
                            output int cnt);
        cnt = 0;
        while (sig(k) !== v && cnt < lim) begin
            @(negedge ref_clk_in);
            cnt++;
        end
        if (cnt >= lim) begin
            err_total++;
            $display("CHECK FAILED wait %0d expected %0h seen timeout", k, v);
            complete_run();
        end
    endtask
    task automatic hold(input string nm, input int k, input logic v,
                        input int cyc);
        repeat (cyc) begin
            @(negedge ref_clk_in);
            check(nm, sig(k), v);
        end
    endtask
    task automatic activate(input logic hr);
        @(negedge ref_clk_in);
        host_rst = hr;
        vsel = 1'($random(seed));
        cmd_n = 1'b0;
        wait_for(0, 1'b1, 10, n);
        check("vcc_5v", vcc_5v, vsel);
    endtask
    task automatic deact(input string why);
        int a, b, c, d;
        wait_for(2, 1'b0, 60, a);
        wait_for(1, 1'b1, 60, b);
        check("clk_stop", card_clk, 1'b0);
        wait_for(0, 1'b0, 60, c);
        check("discharge", vcc_dis, 1'b1);
        wait_for(5, 1'b0, 60, d);
        near("t_io", b, gaps[0]);
        near("t_vcc", c, gaps[1]);
        near("t_dis", d, gaps[2]);
        $display("test %s done", why);
    endtask
    task automatic io_and_clock();
        int cnt;
        logic prev;
        @(negedge ref_clk_in) host_pull = 1'b1;
        wait_for(1, 1'b1, 8, n);
        check("host_oe", hio_oe, 1'b0);
        @(negedge ref_clk_in) host_pull = 1'b0;
        wait_for(1, 1'b0, 8, n);
        // Host sends nothing more until the card answer ends
        @(negedge ref_clk_in) host_rst = 1'b1;
        wait_for(2, 1'b1, 8, n);
        wait_for(4, 1'b1, 60, n);
        check("card_oe", cio_oe, 1'b0);
        wait_for(4, 1'b0, 40, n);
        for (int i = 0; i < 4; i++) begin
            @(negedge ref_clk_in) ratio = 2'(i);
            repeat (100) @(negedge ref_clk_in);
            cnt = 0;
            prev = card_clk;
            repeat (1440) begin
                @(negedge ref_clk_in);
                cnt += (card_clk && !prev) ? 1 : 0;
                prev = card_clk;
            end
            near("clk_rate", cnt, 120 / divs[i]);
        end
        $display("test io and clock done");
    endtask
    initial begin
        repeat (12) @(negedge ref_clk_in);
        rst_b_in = 1'b1;
        check("card_io_oe", cio_oe, 1'b1);
        check("host_io_oe", hio_oe, 1'b0);
        check("vcc_idle", vcc_on, 1'b0);
        cmd_n = 1'b0;
        hold("lockout", 0, 1'b0, 20);
        cmd_n = 1'b1;
        repeat (LOCK + 10) @(negedge ref_clk_in);
        detect = 1'b0;
        ocur = 1'b1;
        wait_for(3, 1'b1, 8, n);
        cmd_n = 1'b0;
        hold("no_card", 0, 1'b0, 20);
        cmd_n = 1'b1;
        detect = 1'b1;
        wait_for(3, 1'b0, 8, n);
        hold("idle_fault", 3, 1'b0, 10);
        ocur = 1'b0;
        $display("test idle done");
        activate(1'b0);
        wait_for(1, 1'b0, 40, n);
        near("t_rx", n, T1 + T2);
        hold("clk_t3", 6, 1'b0, T3 - 2);
        wait_for(6, 1'b1, 60, n);
        io_and_clock();
        @(negedge ref_clk_in) cmd_n = 1'b1;
        deact("command");
        for (int f = 0; f < 4; f++) begin
            repeat (LOCK + 10) @(negedge ref_clk_in);
            activate(1'b1);
            hold("clk_wait", 6, 1'b0, 30);
            host_rst = 1'b0;
            wait_for(6, 1'b1, 60, n);
            host_rst = 1'b1;
            wait_for(2, 1'b1, 8, n);
            detect = (f != 0);
            ocur = (f == 1);
            lfault = (f == 2);
            vvalid = (f != 3);
            wait_for(3, 1'b1, 6, n);
            deact("fault");
            detect = 1'b1;
            ocur = 1'b0;
            lfault = 1'b0;
            vvalid = 1'b1;
            cmd_n = 1'b1;
            wait_for(3, 1'b0, 12, n);
        end
        repeat (LOCK + 10) @(negedge ref_clk_in);
        vvalid = 1'b0;
        activate(1'b0);
        wait_for(3, 1'b1, T1 + 8, n);
        wait_for(0, 1'b0, 3, n);
        wait_for(5, 1'b1, 100, n);
        wait_for(5, 1'b0, 40, n);
        $display("test supply fault done");
        complete_run();
    end
endmodule
